// ===== include/pbfs_pkg.sv
// Shared constants and types for the port B pin function selector
`default_nettype none

package pbfs_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register indices on the plain register port
  localparam logic [1:0] IDX_HIGH_SEL = 2'h0;
  localparam logic [1:0] IDX_LOW_SEL  = 2'h1;
  localparam logic [1:0] IDX_DIR      = 2'h2;
  localparam int         ADDR_W       = 2;
  localparam int         DATA_W       = 16;

  ////////////////////////////////////////////////////////////////////////
  // Values after power-on reset
  localparam logic [15:0] HIGH_SEL_RST = 16'h0000;
  localparam logic [15:0] LOW_SEL_RST  = 16'h0000;
  localparam logic [15:0] DIR_RST      = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Field layout
  localparam int PIN9_MODE_LSB = 2;
  localparam int PIN8_MODE_LSB = 0;
  localparam int HIGH_USED_W   = 4;
  localparam int MODE_W        = 2;
  localparam int LOW_PINS      = 8;
  localparam int PORT_PINS     = 10;

  ////////////////////////////////////////////////////////////////////////
  // Mode field codes
  localparam logic [1:0] MD_GPIO = 2'h0;
  localparam logic [1:0] MD_IRQ  = 2'h1;
  localparam logic [1:0] MD_ADDR = 2'h2;
  localparam logic [1:0] MD_ALT  = 2'h3;

  // Effective pin function after mode override
  typedef enum logic [1:0] {
    PBFS_FN_GPIO,
    PBFS_FN_IN_A,
    PBFS_FN_IN_B,
    PBFS_FN_OUT
  } pbfs_fn_t;

  // Per-pin control bundle
  typedef struct packed {
    pbfs_fn_t fn;
    logic     dir;
    logic     gpio_o;
    logic     alt_o;
  } pbfs_pin_ctl_t;

endpackage : pbfs_pkg

`default_nettype wire

// ===== hdl/pbfs_pin_mux.sv
// One multiplexed port pin with registered outputs
`timescale 1ns/100ps
`default_nettype none

module pbfs_pin_mux
(
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire pbfs_pkg::pbfs_pin_ctl_t ctl,
  input  wire logic                   pin_in,
  output logic                        pin_out,
  output logic                        pin_oe,
  output logic                        gpio_in,
  output logic                        fn_a_in,
  output logic                        fn_b_in
);

  ////////////////////////////////////////////////////////////////////////
  // Selection
  wire sel_gpio = (ctl.fn == pbfs_pkg::PBFS_FN_GPIO);
  wire sel_a    = (ctl.fn == pbfs_pkg::PBFS_FN_IN_A);
  wire sel_b    = (ctl.fn == pbfs_pkg::PBFS_FN_IN_B);
  wire sel_out  = (ctl.fn == pbfs_pkg::PBFS_FN_OUT);

  wire oe_d  = sel_out | (sel_gpio & ctl.dir);
  wire out_d = sel_out ? ctl.alt_o : (sel_gpio & ctl.gpio_o);

  ////////////////////////////////////////////////////////////////////////
  // Output flops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;
      gpio_in <= 1'b0;
      fn_a_in <= 1'b0;
      fn_b_in <= 1'b0;
    end
    else
    begin
      pin_out <= out_d;
      pin_oe  <= oe_d;
      gpio_in <= sel_gpio & pin_in;
      fn_a_in <= sel_a & pin_in;
      fn_b_in <= sel_b & pin_in;
    end
  end

endmodule : pbfs_pin_mux

`default_nettype wire

// ===== hdl/pbfs_top.sv
// Port B function selector: registers, mode override and pin muxes
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Two 16-bit read/write select registers cover ten multiplexed pins.
// - High select register steers only pins 9 and 8.
// - Low select register holds two-bit fields; pins 7..4 sit in 15:8.
// - High register bits 15..4 read zero; software writes zero there.
// - Pin 9: GPIO, interrupt, address 21 (GPIO single-chip), trigger.
// - Pin 8: GPIO, interrupt, address 20, wait; 10/11 GPIO single-chip.
// - Power-on reset clears both select registers, all pins GPIO.
// - Other resets and low-power states keep register contents.
// - Operating mode overrides selections of bus and address pins.
// - In GPIO use, direction bit 1 means output, 0 input.
module pbfs_top
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        single_chip,
  input  wire logic [9:0]  gpio_out,
  input  wire logic        address_bit_21,
  input  wire logic        address_bit_20,
  input  wire logic [7:0]  low_alt_out,
  input  wire logic [9:0]  pin_in,
  output logic      [9:0]  pin_out,
  output logic      [9:0]  pin_oe,
  output logic      [9:0]  gpio_in,
  output logic             ext_interrupt_seven,
  output logic             ext_interrupt_six,
  output logic             converter_trigger_in,
  output logic             wait_request_in,
  output logic      [7:0]  low_alt_in
);

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0]  port_b_high_pin_select_q;
  logic [15:0] port_b_low_pin_select_q;
  logic [9:0]  port_b_direction_q;
  logic [15:0] rdata_d;

  wire wr_high = reg_wr & (reg_addr == pbfs_pkg::IDX_HIGH_SEL);
  wire wr_low  = reg_wr & (reg_addr == pbfs_pkg::IDX_LOW_SEL);
  wire wr_dir  = reg_wr & (reg_addr == pbfs_pkg::IDX_DIR);

  // Cleared only by the power-on reset
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      port_b_high_pin_select_q <=
        pbfs_pkg::HIGH_SEL_RST[pbfs_pkg::HIGH_USED_W-1:0];
      port_b_low_pin_select_q  <= pbfs_pkg::LOW_SEL_RST;
      port_b_direction_q       <= pbfs_pkg::DIR_RST[9:0];
    end
    else
    begin
      // Only the four mode bits are stored
      if (wr_high)
        port_b_high_pin_select_q <=
          reg_wdata[pbfs_pkg::HIGH_USED_W-1:0];
      if (wr_low)
        port_b_low_pin_select_q <= reg_wdata;
      if (wr_dir)
        port_b_direction_q <= reg_wdata[9:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path
  wire rd_high = reg_rd & (reg_addr == pbfs_pkg::IDX_HIGH_SEL);
  wire rd_low  = reg_rd & (reg_addr == pbfs_pkg::IDX_LOW_SEL);
  wire rd_dir  = reg_rd & (reg_addr == pbfs_pkg::IDX_DIR);

  // Upper bits of high register read zero
  assign rdata_d =
    rd_high ? {12'h000, port_b_high_pin_select_q} :
    rd_low  ? port_b_low_pin_select_q :
    rd_dir  ? {6'h00, port_b_direction_q} :
              16'h0000;

  // Read data one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= rdata_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode with single-chip override
  function automatic pbfs_pkg::pbfs_fn_t decode_mode
  (
    input logic [1:0] md,
    input logic       sc,
    input logic       has_b,
    input logic       b_reverts
  );
    pbfs_pkg::pbfs_fn_t fn;
    fn = pbfs_pkg::PBFS_FN_GPIO;
    case (md)
      pbfs_pkg::MD_GPIO: fn = pbfs_pkg::PBFS_FN_GPIO;
      pbfs_pkg::MD_IRQ:  fn = pbfs_pkg::PBFS_FN_IN_A;
      pbfs_pkg::MD_ADDR:
        fn = sc ? pbfs_pkg::PBFS_FN_GPIO : pbfs_pkg::PBFS_FN_OUT;
      pbfs_pkg::MD_ALT:
        fn = (has_b && !(sc && b_reverts)) ?
             pbfs_pkg::PBFS_FN_IN_B : pbfs_pkg::PBFS_FN_GPIO;
      default: fn = pbfs_pkg::PBFS_FN_GPIO;
    endcase
    return fn;
  endfunction : decode_mode

  wire [1:0] pin9_mode =
    port_b_high_pin_select_q[pbfs_pkg::PIN9_MODE_LSB +: 2];
  wire [1:0] pin8_mode =
    port_b_high_pin_select_q[pbfs_pkg::PIN8_MODE_LSB +: 2];

  pbfs_pkg::pbfs_fn_t fn_w [9:0];

  // Pin 9 trigger choice stays in single-chip
  assign fn_w[9] = decode_mode(pin9_mode, single_chip, 1'b1, 1'b0);
  // Pin 8 wait choice reverts in single-chip
  assign fn_w[8] = decode_mode(pin8_mode, single_chip, 1'b1, 1'b1);

  // Low pins: address choice forced to GPIO in single-chip; code 3 always GPIO
  genvar g;
  generate
    for (g = 0; g < pbfs_pkg::LOW_PINS; g++)
    begin : g_low_fn
      assign fn_w[g] = decode_mode(
        port_b_low_pin_select_q[g*pbfs_pkg::MODE_W +: 2],
        single_chip, 1'b0, 1'b0);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin multiplexers
  wire [9:0] alt_w = {address_bit_21, address_bit_20, low_alt_out};
  wire [9:0] fn_a_w;
  wire [1:0] fn_b_w;

  generate
    for (g = 0; g < pbfs_pkg::PORT_PINS; g++)
    begin : g_pin
      pbfs_pkg::pbfs_pin_ctl_t ctl;
      // Direction bit joins the pin control
      assign ctl = '{fn: fn_w[g], dir: port_b_direction_q[g],
                     gpio_o: gpio_out[g], alt_o: alt_w[g]};
      if (g >= pbfs_pkg::LOW_PINS)
      begin : g_hi
        pbfs_pin_mux u_mux
        (
          .clk     (clk),
          .rst_n   (rst_n),
          .ctl     (ctl),
          .pin_in  (pin_in[g]),
          .pin_out (pin_out[g]),
          .pin_oe  (pin_oe[g]),
          .gpio_in (gpio_in[g]),
          .fn_a_in (fn_a_w[g]),
          .fn_b_in (fn_b_w[g-pbfs_pkg::LOW_PINS])
        );
      end
      else
      begin : g_lo
        pbfs_pin_mux u_mux
        (
          .clk     (clk),
          .rst_n   (rst_n),
          .ctl     (ctl),
          .pin_in  (pin_in[g]),
          .pin_out (pin_out[g]),
          .pin_oe  (pin_oe[g]),
          .gpio_in (gpio_in[g]),
          .fn_a_in (fn_a_w[g]),
          .fn_b_in ()
        );
      end
    end
  endgenerate

  assign ext_interrupt_seven  = fn_a_w[9];
  assign ext_interrupt_six    = fn_a_w[8];
  assign converter_trigger_in = fn_b_w[1];
  assign wait_request_in      = fn_b_w[0];
  assign low_alt_in           = fn_a_w[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic first_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end

  rst_clear_a: assert property (
    first_q |-> (port_b_high_pin_select_q == 4'h0) &&
                (port_b_low_pin_select_q == 16'h0000))
    else $error("select registers not clear after reset");

  high_read_zero_a: assert property (
    rd_high |=> (reg_rdata[15:4] == 12'h000) &&
                (reg_rdata[3:0] == $past(port_b_high_pin_select_q)))
    else $error("high select upper bits not zero");

  low_readback_a: assert property (
    (wr_low ##1 rd_low) |=> (reg_rdata == $past(reg_wdata, 2)))
    else $error("low select readback mismatch");

  high_only_pins_a: assert property (
    (wr_high && !wr_low) |=> $stable(port_b_low_pin_select_q))
    else $error("high write changed low select");

  hold_no_write_a: assert property (
    !reg_wr |=> $stable(port_b_high_pin_select_q) &&
                $stable(port_b_low_pin_select_q) &&
                $stable(port_b_direction_q))
    else $error("register changed without write");

  pin9_addr_a: assert property (
    (pin9_mode == pbfs_pkg::MD_ADDR && !single_chip) |=>
      pin_oe[9] && (pin_out[9] == $past(address_bit_21)))
    else $error("pin 9 address output wrong");

  pin9_irq_a: assert property (
    (pin9_mode == pbfs_pkg::MD_IRQ) |=>
      !pin_oe[9] && (ext_interrupt_seven == $past(pin_in[9])) &&
      !gpio_in[9])
    else $error("pin 9 interrupt input wrong");

  pin8_wait_sc_a: assert property (
    (pin8_mode == pbfs_pkg::MD_ALT && single_chip) |=>
      !wait_request_in &&
      (pin_oe[8] == $past(port_b_direction_q[8])))
    else $error("pin 8 wait not reverted in single-chip");

  pin8_wait_a: assert property (
    (pin8_mode == pbfs_pkg::MD_ALT && !single_chip) |=>
      !pin_oe[8] && (wait_request_in == $past(pin_in[8])))
    else $error("pin 8 wait input wrong");

  low_override_a: assert property (
    (port_b_low_pin_select_q[9:8] == pbfs_pkg::MD_ADDR &&
     single_chip) |=>
      (pin_oe[4] == $past(port_b_direction_q[4])))
    else $error("pin 4 mode override failed");

  gpio_dir_a: assert property (
    (!first_q &&
     port_b_low_pin_select_q[11:10] == pbfs_pkg::MD_GPIO) |=>
      (pin_oe[5] == $past(port_b_direction_q[5])) &&
      (pin_out[5] == $past(gpio_out[5])))
    else $error("pin 5 direction not honoured");

  write_update_a: assert property (
    (wr_high && reg_wdata[3:2] == pbfs_pkg::MD_ADDR) ##1
      !single_chip |=> pin_oe[9])
    else $error("pin 9 not updated after write");

  high_write_a: assert property (
    wr_high |=> (port_b_high_pin_select_q == $past(reg_wdata[3:0])))
    else $error("high select write not stored");

  low_write_a: assert property (
    wr_low |=> (port_b_low_pin_select_q == $past(reg_wdata)))
    else $error("low select write not stored");

  dir_write_a: assert property (
    wr_dir |=> (port_b_direction_q == $past(reg_wdata[9:0])))
    else $error("direction write not stored");

  unmapped_read_a: assert property (
    (reg_rd && reg_addr == 2'h3) |=> (reg_rdata == 16'h0000))
    else $error("unmapped index read not zero");

  idle_rdata_a: assert property (
    !reg_rd |=> (reg_rdata == 16'h0000))
    else $error("read data not zero outside read");

  pin9_trig_a: assert property (
    (pin9_mode == pbfs_pkg::MD_ALT) |=>
      !pin_oe[9] && (converter_trigger_in == $past(pin_in[9])) &&
      !ext_interrupt_seven)
    else $error("pin 9 trigger input wrong");

  pin9_addr_sc_a: assert property (
    (pin9_mode == pbfs_pkg::MD_ADDR && single_chip) |=>
      (pin_oe[9] == $past(port_b_direction_q[9])) &&
      (pin_out[9] == $past(gpio_out[9])))
    else $error("pin 9 address not reverted in single-chip");

  pin8_addr_a: assert property (
    (pin8_mode == pbfs_pkg::MD_ADDR && !single_chip) |=>
      pin_oe[8] && (pin_out[8] == $past(address_bit_20)))
    else $error("pin 8 address output wrong");

  pin8_irq_a: assert property (
    (pin8_mode == pbfs_pkg::MD_IRQ) |=>
      !pin_oe[8] && (ext_interrupt_six == $past(pin_in[8])) &&
      !wait_request_in)
    else $error("pin 8 interrupt input wrong");

  low_in_fn_a: assert property (
    (port_b_low_pin_select_q[1:0] == pbfs_pkg::MD_IRQ) |=>
      !pin_oe[0] && (low_alt_in[0] == $past(pin_in[0])) && !gpio_in[0])
    else $error("pin 0 input function wrong");

  low_out_fn_a: assert property (
    (port_b_low_pin_select_q[1:0] == pbfs_pkg::MD_ADDR && !single_chip) |=>
      pin_oe[0] && (pin_out[0] == $past(low_alt_out[0])))
    else $error("pin 0 output function wrong");

  low_sc_gpio_a: assert property (
    (port_b_low_pin_select_q[1:0] == pbfs_pkg::MD_ADDR && single_chip) |=>
      (pin_oe[0] == $past(port_b_direction_q[0])) && !low_alt_in[0])
    else $error("pin 0 output not reverted in single-chip");

  pin9_trig_c: cover property (
    pin9_mode == pbfs_pkg::MD_ALT ##1 converter_trigger_in);
  low_alt_c: cover property (
    wr_low ##2 (low_alt_in != 8'h00));
  sc_override_c: cover property (
    (pin8_mode == pbfs_pkg::MD_ADDR) && single_chip ##1 !pin_oe[8]);
  pin8_wait_c: cover property (
    (pin8_mode == pbfs_pkg::MD_ALT) && !single_chip ##1 wait_request_in);
  gpio_drive_c: cover property (
    (pin9_mode == pbfs_pkg::MD_GPIO) && port_b_direction_q[9] ##1 pin_oe[9]);

endmodule : pbfs_top

`default_nettype wire

// ===== dv/pbfs_pin_partner.sv
// Outside world model for the ten port B pins
`timescale 1ns/100ps
`default_nettype none

module pbfs_pin_partner
(
  input  wire logic [9:0] pin_out,
  input  wire logic [9:0] pin_oe,
  input  wire logic [9:0] ext_lvl,
  output logic      [9:0] pin_in
);
  ////////////////////////////////////////////////////////////////////////
  // wire level resolve
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule : pbfs_pin_partner

`default_nettype wire

// ===== dv/pbfs_top_tb.sv
// Self-checking bench for the port B function selector
`timescale 1ns/100ps
`default_nettype none

module pbfs_top_tb;
  logic        clk;
  logic        rst_n;
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        single_chip;
  logic [9:0]  gpio_out;
  logic        address_bit_21;
  logic        address_bit_20;
  logic [7:0]  low_alt_out;
  logic [9:0]  pin_in;
  logic [9:0]  pin_out;
  logic [9:0]  pin_oe;
  logic [9:0]  gpio_in;
  logic        ext_interrupt_seven;
  logic        ext_interrupt_six;
  logic        trig;
  logic        wreq;
  logic [7:0]  low_alt_in;
  logic [9:0]  ext_lvl;
  int          fails;
  int          samples_checked;

  pbfs_top DUT (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .single_chip(single_chip), .gpio_out(gpio_out),
    .address_bit_21(address_bit_21), .address_bit_20(address_bit_20),
    .low_alt_out(low_alt_out),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .gpio_in(gpio_in),
    .ext_interrupt_seven(ext_interrupt_seven),
    .ext_interrupt_six(ext_interrupt_six),
    .converter_trigger_in(trig), .wait_request_in(wreq),
    .low_alt_in(low_alt_in));

  pbfs_pin_partner PART (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_lvl(ext_lvl), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////
  // Clock and tasks
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clk);
  endtask : rd

  task automatic pin_chk(input logic [1:0] md, input logic sc,
                         input logic d);
    logic       g9;
    logic       g8;
    logic       gl;
    logic [9:0] oe;
    logic [9:0] ou;
    logic [9:0] gs;
    g9 = (md == 2'h0) || (md == 2'h2 && sc);
    g8 = (md == 2'h0) || (md[1] && sc);
    gl = (md != 2'h1) && !(md == 2'h2 && !sc);
    oe = {g9 ? d : md == 2'h2, g8 ? d : md == 2'h2,
          {8{gl ? d : md == 2'h2}}};
    ou = {g9 ? gpio_out[9] : address_bit_21,
          g8 ? gpio_out[8] : address_bit_20,
          gl ? gpio_out[7:0] : low_alt_out};
    gs = {g9, g8, {8{gl}}};
    #1;
    chk({6'h00, pin_oe}, {6'h00, oe});
    chk({6'h00, pin_out & oe}, {6'h00, ou & oe});
    chk({6'h00, gpio_in},
        {6'h00, gs & ((oe & ou) | (~oe & ext_lvl))});
    chk({14'h0000, ext_interrupt_seven, trig},
        {14'h0000, md == 2'h1 && ext_lvl[9],
         md == 2'h3 && ext_lvl[9]});
    chk({14'h0000, ext_interrupt_six, wreq},
        {14'h0000, md == 2'h1 && ext_lvl[8],
         md == 2'h3 && !sc && ext_lvl[8]});
    chk({8'h00, low_alt_in},
        {8'h00, {8{md == 2'h1}} & ext_lvl[7:0]});
    @(posedge clk);
  endtask : pin_chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk);
    fails++;
    tally_and_finish();
  end

  ////////////////////////////////////////////////////////////////////////
  // Test sequence
  initial
  begin
    fails = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    single_chip = 1'b0;
    gpio_out = 10'h2aa;
    address_bit_21 = 1'b0;
    address_bit_20 = 1'b1;
    low_alt_out = 8'h5a;
    ext_lvl = 10'h3ff;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(pbfs_pkg::IDX_HIGH_SEL, pbfs_pkg::HIGH_SEL_RST);
    rd(pbfs_pkg::IDX_LOW_SEL, pbfs_pkg::LOW_SEL_RST);
    pin_chk(2'h0, 1'b0, 1'b0);
    $display("test reset values done");
    wr(pbfs_pkg::IDX_HIGH_SEL, 16'h000f);
    rd(pbfs_pkg::IDX_HIGH_SEL, 16'h000f);
    wr(pbfs_pkg::IDX_LOW_SEL, 16'ha5c3);
    rd(pbfs_pkg::IDX_LOW_SEL, 16'ha5c3);
    wr(2'h3, 16'hffff);
    rd(2'h3, 16'h0000);
    rd(pbfs_pkg::IDX_HIGH_SEL, 16'h000f);
    $display("test register access done");
    wr(pbfs_pkg::IDX_HIGH_SEL, 16'h0008);
    #1 chk({15'h0000, pin_oe[9]}, 16'h0001);
    $display("test update latency done");
    for (int d = 0; d < 2; d++)
      for (int sc = 0; sc < 2; sc++)
        for (int md = 0; md < 4; md++)
        begin
          single_chip <= sc[0];
          ext_lvl     <= d[0] ? 10'h155 : 10'h3ff;
          wr(pbfs_pkg::IDX_DIR, d[0] ? 16'h03ff : 16'h0000);
          wr(pbfs_pkg::IDX_HIGH_SEL, {12'h000, md[1:0], md[1:0]});
          wr(pbfs_pkg::IDX_LOW_SEL, {8{md[1:0]}});
          repeat (3) @(posedge clk);
          pin_chk(md[1:0], sc[0], d[0]);
        end
    $display("test function select done");
    single_chip <= 1'b0;
    rd(pbfs_pkg::IDX_HIGH_SEL, 16'h000f);
    rd(pbfs_pkg::IDX_LOW_SEL, 16'hffff);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(pbfs_pkg::IDX_HIGH_SEL, 16'h0000);
    rd(pbfs_pkg::IDX_LOW_SEL, 16'h0000);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule : pbfs_top_tb

`default_nettype wire
